// ### logic/cet_map.vh
// Constants for the cascadable 8-bit timer block: register map, field positions and encodings.
// Assumes a word-addressed Avalon-MM slave with 32-bit data; registers use the low byte.
`ifndef CET_MAP_VH
`define CET_MAP_VH

// Word address layout: per-channel registers at channel*8 + register index.
`define CET_ADDR_W 6
`define CET_CHAN_MSB 5
`define CET_CHAN_LSB 3
`define CET_REG_MSB 2
`define CET_REG_LSB 0
`define CET_CHAN_COUNT 3'h6
`define CET_REG_COUNT 3'h0
`define CET_REG_REF_A 3'h1
`define CET_REG_REF_B 3'h2
`define CET_REG_CTRL 3'h3
`define CET_REG_CTRL_STATUS 3'h4
`define CET_ADDR_YX_CASCADE 6'h30
`define CET_ADDR_BA_CASCADE 6'h31
`define CET_ADDR_RISE_YX 6'h32
`define CET_ADDR_FALL_YX 6'h33
`define CET_ADDR_RISE_BA 6'h34
`define CET_ADDR_FALL_BA 6'h35

// Timer control register fields.
`define CET_CKS_MSB 2
`define CET_CKS_LSB 0
`define CET_CLR_MSB 4
`define CET_CLR_LSB 3
// Control/status register fields.
`define CET_OS_MSB 3
`define CET_OS_LSB 0
`define CET_OS_A_MSB 1
`define CET_OS_A_LSB 0
`define CET_OS_B_MSB 3
`define CET_OS_B_LSB 2
`define CET_FLAG_OVF 5
`define CET_FLAG_A 6
`define CET_FLAG_B 7
// Cascade control register fields.
`define CET_CASC_ARM 3
`define CET_CASC_UPPER 4
`define CET_CASC_LOWER 5

// Clock select encodings.
`define CET_CKS_STOP 3'h0
`define CET_CKS_DIV8 3'h1
`define CET_CKS_DIV64 3'h2
`define CET_CKS_DIV8192 3'h3
`define CET_CKS_CASCADE 3'h4
`define CET_CKS_EXT_RISE 3'h5
`define CET_CKS_EXT_FALL 3'h6
`define CET_CKS_EXT_BOTH 3'h7
// Counter clear select encodings.
`define CET_CLR_NONE 2'h0
`define CET_CLR_MATCH_A 2'h1
`define CET_CLR_MATCH_B 2'h2
`define CET_CLR_EXT 2'h3
// Output action encodings; a larger code has higher priority.
`define CET_OUT_KEEP 2'h0
`define CET_OUT_LOW 2'h1
`define CET_OUT_HIGH 2'h2
`define CET_OUT_TOGGLE 2'h3

// Prescaler.
`define CET_PRE_W 13
`define CET_PRE_RESET 13'h0000
`define CET_PRE_STEP 13'h0001
`define CET_PRE_MASK8 13'h0007
`define CET_PRE_MASK64 13'h003f
`define CET_PRE_MASK8192 13'h1fff

// Values.
`define CET_COUNT_RESET 8'h00
`define CET_COUNT_MAX 8'hff
`define CET_COUNT_STEP 8'h01
`define CET_REF_RESET 8'hff
`define CET_CTRL_RESET 5'h00
`define CET_OS_RESET 4'h0
`define CET_BYTE_ZERO 8'h00
`define CET_RD_PAD 24'h000000

`endif

// ### logic/cet_timer.v
// Six 8-bit compare timers in three cascadable pairs, with an Avalon-MM register slave.
// Assumes one 100 MHz clock; all timer pins are asynchronous and are synchronised here.
//
// The implementer's own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "cet_map.vh"

// Behaviour
// - Clear select high 0, low 1 clears the counter on match A.
// - Output select 0110 drives output high on match A, low on match B.
// - Match flags A and B set when counter equals the reference register.
// - Match pulse fires at the count clock that leaves the equal value.
// - Each match pulse toggles, sets, clears or keeps the output per select field.
// - Clear select bits choose counter clear on match A or match B.
// - External reset rising edge clears counter; pulse must last 1.5 states.
// - Overflow flag sets when the counter wraps from all ones to zero.
// - Clock select 100 in channel zero or one cascades that pair.
// - Channel zero at 100 makes one 16-bit counter, zero upper, one lower.
// - Zero/one 16-bit: zero flags on full match, one flags on low byte.
// - Zero/one 16-bit: zero's clear clears both bytes; one's clear ignored.
// - Zero/one 16-bit: zero's pin follows full match, one's pin low byte.
// - Channel one at 100 counts channel zero match A events.
// - Upper yx at 100 with its cascade bit forms 16-bit counter, yx.
// - Yx 16-bit: upper clears only upper byte; flags and pins bytewise.
// - Yx 16-bit: lower yx channel's own clear settings still clear lower byte.
// - Lower yx at 100 with its cascade bit counts upper yx match A.
// - Falling after rising on lower yx capture input copies count into both captures.
// - Upper ba at 100 with its cascade bit forms 16-bit counter, ba.
// - Ba 16-bit: upper clears only upper byte; lower still clears; bytewise flags.
// - Lower ba at 100 with its cascade bit counts upper ba match A.
// - Capture arm enables one ba pulse capture, then hardware clears the arm.
module cet_timer (
	// Clock and reset
	input wire clk_in,
	input wire reset_in,
	// Avalon-MM slave
	input wire [`CET_ADDR_W-1:0] avs_address_in,
	input wire avs_read_in,
	input wire avs_write_in,
	input wire [31:0] avs_writedata_in,
	input wire [3:0] avs_byteenable_in,
	output wire [31:0] avs_readdata_out,
	output wire avs_waitrequest_out,
	// Timer pins
	input wire [5:0] ext_clock_in,
	input wire ext_reset_pin_zero_in,
	input wire ext_reset_pin_upper_yx_in,
	input wire ext_reset_pin_upper_ba_in,
	input wire capture_input_lower_yx_in,
	input wire capture_input_lower_ba_in,
	output wire out_pin_zero_out,
	output wire out_pin_one_out,
	output wire out_pin_upper_yx_out,
	output wire out_pin_lower_yx_out,
	output wire out_pin_upper_ba_out,
	output wire out_pin_lower_ba_out
);

	// Channel state: 0 zero, 1 one, 2 upper yx, 3 lower yx, 4 upper ba, 5 lower ba.
	reg [7:0] count_reg_q [0:5];
	reg [7:0] reference_a_reg_q [0:5];
	reg [7:0] reference_b_reg_q [0:5];
	reg [4:0] timer_ctrl_reg_q [0:5];
	reg [3:0] output_select_field_q [0:5];
	reg [5:0] match_a_flag_q;
	reg [5:0] match_b_flag_q;
	reg [5:0] overflow_flag_q;
	reg [5:0] out_pin_q;
	// Cascade control and capture; index 0 is yx, 1 is ba.
	reg [1:0] upper_cascade_sel_q;
	reg [1:0] lower_cascade_sel_q;
	reg [1:0] capture_arm_q;
	reg [1:0] rise_seen_q;
	reg [7:0] rise_capture_reg_q [0:1];
	reg [7:0] fall_capture_reg_q [0:1];
	reg [`CET_PRE_W-1:0] prescale_q;
	// Pin synchronisers: bit 5..0 ext clocks, 6 reset zero, 7 reset yx, 8 capture yx, 9 reset ba, 10 capture ba.
	reg [10:0] pin_s1_q;
	reg [10:0] pin_s2_q;
	reg [10:0] pin_s3_q;
	// Bus slave.
	reg waitrequest_q;
	reg [7:0] readdata_q;

	wire [10:0] pin_rise;
	wire [10:0] pin_fall;
	wire [5:0] ext_reset_rise;
	wire [2:0] upper_sel_all;
	wire [2:0] lower_sel_all;
	wire bus_wr;
	wire [2:0] wr_chan;
	wire [2:0] wr_reg;

	reg [5:0] own_tick;
	reg [5:0] tick;
	reg [5:0] match_a;
	reg [5:0] match_b;
	reg [5:0] clear;
	reg [5:0] wrap;
	reg mode16;
	reg match_count;
	reg [7:0] rd_byte;
	integer i;
	integer p;
	integer h;
	integer l;
	// Each process owns its loop index so no variable has two drivers.
	integer j;
	integer k;

	function src_tick;
		input [2:0] cks;
		input [`CET_PRE_W-1:0] pre;
		input rise;
		input fall;
		begin
			case (cks)
			`CET_CKS_DIV8: src_tick = (pre & `CET_PRE_MASK8) == `CET_PRE_MASK8;
			`CET_CKS_DIV64: src_tick = (pre & `CET_PRE_MASK64) == `CET_PRE_MASK64;
			`CET_CKS_DIV8192: src_tick = (pre & `CET_PRE_MASK8192) == `CET_PRE_MASK8192;
			`CET_CKS_EXT_RISE: src_tick = rise;
			`CET_CKS_EXT_FALL: src_tick = fall;
			`CET_CKS_EXT_BOTH: src_tick = rise | fall;
			default: src_tick = 1'b0;
			endcase
		end
	endfunction

	function clear_hit;
		input [1:0] sel;
		input ma;
		input mb;
		input ext;
		begin
			clear_hit = ((sel == `CET_CLR_MATCH_A) & ma) | ((sel == `CET_CLR_MATCH_B) & mb) |
				((sel == `CET_CLR_EXT) & ext);
		end
	endfunction

	// Picks the action with the larger code when A and B coincide.
	function [1:0] out_action;
		input [3:0] os;
		input ma;
		input mb;
		reg [1:0] act_a;
		reg [1:0] act_b;
		begin
			act_a = ma ? os[`CET_OS_A_MSB:`CET_OS_A_LSB] : `CET_OUT_KEEP;
			act_b = mb ? os[`CET_OS_B_MSB:`CET_OS_B_LSB] : `CET_OUT_KEEP;
			out_action = (act_a > act_b) ? act_a : act_b;
		end
	endfunction

	// Edge detection reads only the second and third stages; the first stage may be metastable.
	assign pin_rise = pin_s2_q & ~pin_s3_q;
	assign pin_fall = ~pin_s2_q & pin_s3_q;
	// Channel one has no reset pin; the lower channels share their capture pins as reset.
	assign ext_reset_rise = {pin_rise[10], pin_rise[9], pin_rise[8], pin_rise[7], 1'b0, pin_rise[6]};
	assign upper_sel_all = {upper_cascade_sel_q, 1'b1};
	assign lower_sel_all = {lower_cascade_sel_q, 1'b1};
	assign bus_wr = avs_write_in & ~waitrequest_q & avs_byteenable_in[0];
	assign wr_chan = avs_address_in[`CET_CHAN_MSB:`CET_CHAN_LSB];
	assign wr_reg = avs_address_in[`CET_REG_MSB:`CET_REG_LSB];

	// Count, match and clear events for the three pairs.
	always @* begin
		own_tick = 6'h00;
		tick = 6'h00;
		match_a = 6'h00;
		match_b = 6'h00;
		clear = 6'h00;
		wrap = 6'h00;
		mode16 = 1'b0;
		match_count = 1'b0;
		for (k = 0; k < 6; k = k + 1) begin
			own_tick[k] = src_tick(timer_ctrl_reg_q[k][`CET_CKS_MSB:`CET_CKS_LSB], prescale_q,
				pin_rise[k], pin_fall[k]);
		end
		for (p = 0; p < 3; p = p + 1) begin
			h = 2 * p;
			l = 2 * p + 1;
			mode16 = (timer_ctrl_reg_q[h][`CET_CKS_MSB:`CET_CKS_LSB] == `CET_CKS_CASCADE) &
				upper_sel_all[p];
			match_count = (timer_ctrl_reg_q[l][`CET_CKS_MSB:`CET_CKS_LSB] == `CET_CKS_CASCADE) &
				lower_sel_all[p];
			if (mode16 && match_count) begin
				// Both modes at once starve both counters of clocks.
				clear[h] = clear_hit(timer_ctrl_reg_q[h][`CET_CLR_MSB:`CET_CLR_LSB], 1'b0, 1'b0,
					ext_reset_rise[h]);
				clear[l] = clear_hit(timer_ctrl_reg_q[l][`CET_CLR_MSB:`CET_CLR_LSB], 1'b0, 1'b0,
					ext_reset_rise[l]);
			end else if (mode16) begin
				tick[l] = own_tick[l];
				match_a[l] = tick[l] & (count_reg_q[l] == reference_a_reg_q[l]);
				match_b[l] = tick[l] & (count_reg_q[l] == reference_b_reg_q[l]);
				if (p == 0) begin
					match_a[h] = tick[l] & ({count_reg_q[h], count_reg_q[l]} ==
						{reference_a_reg_q[h], reference_a_reg_q[l]});
					match_b[h] = tick[l] & ({count_reg_q[h], count_reg_q[l]} ==
						{reference_b_reg_q[h], reference_b_reg_q[l]});
					clear[h] = clear_hit(timer_ctrl_reg_q[h][`CET_CLR_MSB:`CET_CLR_LSB], match_a[h],
						match_b[h], ext_reset_rise[h]);
					clear[l] = clear[h];
					tick[h] = tick[l] & (count_reg_q[l] == `CET_COUNT_MAX) & ~clear[l];
				end else begin
					clear[l] = clear_hit(timer_ctrl_reg_q[l][`CET_CLR_MSB:`CET_CLR_LSB], match_a[l],
						match_b[l], ext_reset_rise[l]);
					tick[h] = tick[l] & (count_reg_q[l] == `CET_COUNT_MAX) & ~clear[l];
					match_a[h] = tick[h] & (count_reg_q[h] == reference_a_reg_q[h]);
					match_b[h] = tick[h] & (count_reg_q[h] == reference_b_reg_q[h]);
					clear[h] = clear_hit(timer_ctrl_reg_q[h][`CET_CLR_MSB:`CET_CLR_LSB], match_a[h],
						match_b[h], ext_reset_rise[h]);
				end
			end else begin
				tick[h] = own_tick[h];
				match_a[h] = tick[h] & (count_reg_q[h] == reference_a_reg_q[h]);
				match_b[h] = tick[h] & (count_reg_q[h] == reference_b_reg_q[h]);
				clear[h] = clear_hit(timer_ctrl_reg_q[h][`CET_CLR_MSB:`CET_CLR_LSB], match_a[h],
					match_b[h], ext_reset_rise[h]);
				tick[l] = match_count ? match_a[h] : own_tick[l];
				match_a[l] = tick[l] & (count_reg_q[l] == reference_a_reg_q[l]);
				match_b[l] = tick[l] & (count_reg_q[l] == reference_b_reg_q[l]);
				clear[l] = clear_hit(timer_ctrl_reg_q[l][`CET_CLR_MSB:`CET_CLR_LSB], match_a[l],
					match_b[l], ext_reset_rise[l]);
			end
		end
		for (k = 0; k < 6; k = k + 1) begin
			wrap[k] = tick[k] & (count_reg_q[k] == `CET_COUNT_MAX) & ~clear[k];
		end
	end

	// Register read mux; unmapped addresses read as zero.
	always @* begin
		rd_byte = `CET_BYTE_ZERO;
		if (wr_chan < `CET_CHAN_COUNT) begin
			case (wr_reg)
			`CET_REG_COUNT: rd_byte = count_reg_q[wr_chan];
			`CET_REG_REF_A: rd_byte = reference_a_reg_q[wr_chan];
			`CET_REG_REF_B: rd_byte = reference_b_reg_q[wr_chan];
			`CET_REG_CTRL: rd_byte = {3'h0, timer_ctrl_reg_q[wr_chan]};
			`CET_REG_CTRL_STATUS: rd_byte = {match_b_flag_q[wr_chan], match_a_flag_q[wr_chan],
				overflow_flag_q[wr_chan], 1'b0, output_select_field_q[wr_chan]};
			default: rd_byte = `CET_BYTE_ZERO;
			endcase
		end else begin
			case (avs_address_in)
			`CET_ADDR_YX_CASCADE: rd_byte = {2'h0, lower_cascade_sel_q[0], upper_cascade_sel_q[0],
				capture_arm_q[0], 3'h0};
			`CET_ADDR_BA_CASCADE: rd_byte = {2'h0, lower_cascade_sel_q[1], upper_cascade_sel_q[1],
				capture_arm_q[1], 3'h0};
			`CET_ADDR_RISE_YX: rd_byte = rise_capture_reg_q[0];
			`CET_ADDR_FALL_YX: rd_byte = fall_capture_reg_q[0];
			`CET_ADDR_RISE_BA: rd_byte = rise_capture_reg_q[1];
			`CET_ADDR_FALL_BA: rd_byte = fall_capture_reg_q[1];
			default: rd_byte = `CET_BYTE_ZERO;
			endcase
		end
	end

	// One wait cycle per access keeps read data registered and the timing fixed.
	always @(posedge clk_in) begin
		if (reset_in) begin
			waitrequest_q <= 1'b1;
			readdata_q <= `CET_BYTE_ZERO;
		end else begin
			waitrequest_q <= ~((avs_read_in | avs_write_in) & waitrequest_q);
			if (avs_read_in && waitrequest_q) begin
				readdata_q <= rd_byte;
			end
		end
	end

	always @(posedge clk_in) begin
		if (reset_in) begin
			pin_s1_q <= 11'h000;
			pin_s2_q <= 11'h000;
			pin_s3_q <= 11'h000;
			prescale_q <= `CET_PRE_RESET;
		end else begin
			pin_s1_q <= {capture_input_lower_ba_in, ext_reset_pin_upper_ba_in, capture_input_lower_yx_in,
				ext_reset_pin_upper_yx_in, ext_reset_pin_zero_in, ext_clock_in};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			prescale_q <= prescale_q + `CET_PRE_STEP;
		end
	end

	// Channel registers. A clear beats a bus write, and a bus write beats a count.
	always @(posedge clk_in) begin
		for (i = 0; i < 6; i = i + 1) begin
			if (reset_in) begin
				count_reg_q[i] <= `CET_COUNT_RESET;
				reference_a_reg_q[i] <= `CET_REF_RESET;
				reference_b_reg_q[i] <= `CET_REF_RESET;
				timer_ctrl_reg_q[i] <= `CET_CTRL_RESET;
				output_select_field_q[i] <= `CET_OS_RESET;
				match_a_flag_q[i] <= 1'b0;
				match_b_flag_q[i] <= 1'b0;
				overflow_flag_q[i] <= 1'b0;
				out_pin_q[i] <= 1'b0;
			end else begin
				if (clear[i]) begin
					count_reg_q[i] <= `CET_COUNT_RESET;
				end else if (bus_wr && wr_chan == i[2:0] && wr_reg == `CET_REG_COUNT) begin
					count_reg_q[i] <= avs_writedata_in[7:0];
				end else if (tick[i]) begin
					count_reg_q[i] <= count_reg_q[i] + `CET_COUNT_STEP;
				end
				if (bus_wr && wr_chan == i[2:0] && wr_reg == `CET_REG_REF_A) begin
					reference_a_reg_q[i] <= avs_writedata_in[7:0];
				end
				if (bus_wr && wr_chan == i[2:0] && wr_reg == `CET_REG_REF_B) begin
					reference_b_reg_q[i] <= avs_writedata_in[7:0];
				end
				if (bus_wr && wr_chan == i[2:0] && wr_reg == `CET_REG_CTRL) begin
					timer_ctrl_reg_q[i] <= avs_writedata_in[`CET_CLR_MSB:`CET_CKS_LSB];
				end
				if (bus_wr && wr_chan == i[2:0] && wr_reg == `CET_REG_CTRL_STATUS) begin
					output_select_field_q[i] <= avs_writedata_in[`CET_OS_MSB:`CET_OS_LSB];
					// Flags clear on a written 0; a match in the same cycle still sets them.
					match_a_flag_q[i] <= match_a[i] | (match_a_flag_q[i] & avs_writedata_in[`CET_FLAG_A]);
					match_b_flag_q[i] <= match_b[i] | (match_b_flag_q[i] & avs_writedata_in[`CET_FLAG_B]);
					overflow_flag_q[i] <= wrap[i] | (overflow_flag_q[i] & avs_writedata_in[`CET_FLAG_OVF]);
				end else begin
					match_a_flag_q[i] <= match_a_flag_q[i] | match_a[i];
					match_b_flag_q[i] <= match_b_flag_q[i] | match_b[i];
					overflow_flag_q[i] <= overflow_flag_q[i] | wrap[i];
				end
				case (out_action(output_select_field_q[i], match_a[i], match_b[i]))
				`CET_OUT_LOW: out_pin_q[i] <= 1'b0;
				`CET_OUT_HIGH: out_pin_q[i] <= 1'b1;
				`CET_OUT_TOGGLE: out_pin_q[i] <= ~out_pin_q[i];
				default: out_pin_q[i] <= out_pin_q[i];
				endcase
			end
		end
	end

	// Cascade control and single-shot pulse capture on the lower yx and lower ba channels.
	always @(posedge clk_in) begin
		for (j = 0; j < 2; j = j + 1) begin
			if (reset_in) begin
				upper_cascade_sel_q[j] <= 1'b0;
				lower_cascade_sel_q[j] <= 1'b0;
				capture_arm_q[j] <= 1'b0;
				rise_seen_q[j] <= 1'b0;
				rise_capture_reg_q[j] <= `CET_COUNT_RESET;
				fall_capture_reg_q[j] <= `CET_COUNT_RESET;
			end else begin
				if (capture_arm_q[j] && rise_seen_q[j] && pin_fall[8 + 2 * j]) begin
					rise_capture_reg_q[j] <= count_reg_q[3 + 2 * j];
					fall_capture_reg_q[j] <= count_reg_q[3 + 2 * j];
					capture_arm_q[j] <= 1'b0;
					rise_seen_q[j] <= 1'b0;
				end else if (capture_arm_q[j] && pin_rise[8 + 2 * j]) begin
					rise_seen_q[j] <= 1'b1;
				end else if (!capture_arm_q[j]) begin
					rise_seen_q[j] <= 1'b0;
				end
				// A write re-arms even in the cycle the previous capture completes.
				if (bus_wr && avs_address_in == (j == 0 ? `CET_ADDR_YX_CASCADE : `CET_ADDR_BA_CASCADE)) begin
					upper_cascade_sel_q[j] <= avs_writedata_in[`CET_CASC_UPPER];
					lower_cascade_sel_q[j] <= avs_writedata_in[`CET_CASC_LOWER];
					capture_arm_q[j] <= avs_writedata_in[`CET_CASC_ARM];
				end
			end
		end
	end

	assign avs_readdata_out = {`CET_RD_PAD, readdata_q};
	assign avs_waitrequest_out = waitrequest_q;
	assign out_pin_zero_out = out_pin_q[0];
	assign out_pin_one_out = out_pin_q[1];
	assign out_pin_upper_yx_out = out_pin_q[2];
	assign out_pin_lower_yx_out = out_pin_q[3];
	assign out_pin_upper_ba_out = out_pin_q[4];
	assign out_pin_lower_ba_out = out_pin_q[5];

endmodule // cet_timer
`default_nettype wire

// ### verif/cet_timer_props.sv
// Checker for the register bus handshake and the reset state of the timer block.
// Assumes it is bound to cet_timer and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module cet_timer_props (
	// Clock and reset
	input wire clk_in,
	input wire reset_in,
	// Register bus
	input wire avs_read_in,
	input wire avs_write_in,
	input wire [31:0] avs_readdata_out,
	input wire avs_waitrequest_out,
	// Timer outputs
	input wire out_pin_zero_out,
	input wire out_pin_one_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	sequence s_req;
		(avs_read_in || avs_write_in) && avs_waitrequest_out;
	endsequence
	sequence s_ack;
		!avs_waitrequest_out ##1 avs_waitrequest_out;
	endsequence
	chk_ack_one_wait: assert property (s_req |=> s_ack)
		else $error("request not answered after exactly one wait cycle");
	chk_idle_no_ack: assert property (!(avs_read_in || avs_write_in) && avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("acknowledge without a request");
	chk_wait_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("waitrequest low for more than one cycle");
	chk_ack_needs_req: assert property ($fell(avs_waitrequest_out) |-> $past(avs_read_in) || $past(avs_write_in))
		else $error("waitrequest fell with no request pending");
	chk_data_on_ack: assert property ($changed(avs_readdata_out) |-> !avs_waitrequest_out)
		else $error("read data changed outside an acknowledge");
	chk_pad_zero: assert property (avs_readdata_out[31:8] == 24'h000000)
		else $error("upper read data bits not zero");
	// These two must hold while reset is applied, so they carry no disable condition.
	chk_reset_bus: assert property (disable iff (1'b0) reset_in |=> avs_waitrequest_out && avs_readdata_out == 32'h0)
		else $error("bus outputs not cleared by reset");
	chk_reset_pins: assert property (disable iff (1'b0) reset_in |=> !out_pin_zero_out && !out_pin_one_out)
		else $error("timer outputs not cleared by reset");
endmodule // cet_timer_props
bind cet_timer cet_timer_props u_props (
	.clk_in(clk_in),
	.reset_in(reset_in),
	.avs_read_in(avs_read_in),
	.avs_write_in(avs_write_in),
	.avs_readdata_out(avs_readdata_out),
	.avs_waitrequest_out(avs_waitrequest_out),
	.out_pin_zero_out(out_pin_zero_out),
	.out_pin_one_out(out_pin_one_out)
);
`default_nettype wire

// ### verif/cet_pins.sv
// Model of the board around the timer: external count clocks, reset pins and capture pins.
// Assumes the testbench calls its tasks; pins rest low and change just after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module cet_pins (
	// Clock
	input wire clk_in,
	// Pins into the timer
	output var logic [5:0] ext_clock_out,
	output var logic [4:0] pin_out
);
	initial begin
		ext_clock_out = 6'h00;
		pin_out = 5'h00;
	end
	// Each level lasts three system clocks, which also covers the synchroniser.
	task automatic pulse_clock(input int ch, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_in);
			ext_clock_out[ch] <= 1'b1;
			repeat (3) @(posedge clk_in);
			ext_clock_out[ch] <= 1'b0;
			repeat (2) @(posedge clk_in);
		end
	endtask
	// Reset and capture pulses are four clocks wide, above the minimum width.
	task automatic pulse_pin(input int idx);
		@(posedge clk_in);
		pin_out[idx] <= 1'b1;
		repeat (4) @(posedge clk_in);
		pin_out[idx] <= 1'b0;
	endtask
endmodule // cet_pins
`default_nettype wire

// ### verif/cet_timer_tb.sv
// Self-checking testbench for the cascadable timer block.
// Assumes the design's exact one-wait-cycle bus answer and 8-clock prescaler ticks.
`timescale 1ns/100ps
`default_nettype none
module cet_timer_tb;
	logic clk_in = 1'b0;
	logic reset_in, avs_read_in, avs_write_in;
	logic [5:0] avs_address_in;
	logic [31:0] avs_writedata_in;
	logic [3:0] avs_byteenable_in;
	wire [31:0] avs_readdata_out;
	wire avs_waitrequest_out;
	wire [5:0] ext_clock;
	wire [4:0] pins;
	wire [5:0] outs;
	int n_fail, samples_checked, cycles;
	always #5 clk_in = ~clk_in;
	cet_pins u_pins (.clk_in(clk_in), .ext_clock_out(ext_clock), .pin_out(pins));
	cet_timer u_dut (.clk_in(clk_in), .reset_in(reset_in), .avs_address_in(avs_address_in),
		.avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
		.avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out), .ext_clock_in(ext_clock),
		.ext_reset_pin_zero_in(pins[0]), .ext_reset_pin_upper_yx_in(pins[1]),
		.ext_reset_pin_upper_ba_in(pins[2]), .capture_input_lower_yx_in(pins[3]),
		.capture_input_lower_ba_in(pins[4]), .out_pin_zero_out(outs[0]), .out_pin_one_out(outs[1]),
		.out_pin_upper_yx_out(outs[2]), .out_pin_lower_yx_out(outs[3]),
		.out_pin_upper_ba_out(outs[4]), .out_pin_lower_ba_out(outs[5]));
	task automatic tally_and_finish();
		if (n_fail == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// A hung handshake would otherwise stall the run forever.
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 30000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic check1(input string what, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic bus_write(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk_in);
		avs_address_in <= a;
		avs_writedata_in <= {24'h000000, d};
		avs_write_in <= 1'b1;
		do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
		avs_write_in <= 1'b0;
	endtask
	task automatic bus_read(input logic [5:0] a, output logic [7:0] d);
		@(posedge clk_in);
		avs_address_in <= a;
		avs_read_in <= 1'b1;
		do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
		d = avs_readdata_out[7:0];
		avs_read_in <= 1'b0;
	endtask
	task automatic do_reset();
		@(posedge clk_in);
		reset_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		reset_in <= 1'b0;
	endtask
	task automatic time_level(input logic lvl, output int n);
		n = 0;
		while (outs[0] === lvl && n < 200) begin
			@(posedge clk_in);
			n++;
		end
	endtask
	task automatic test_reset_values();
		logic [7:0] v;
		logic [7:0] exp [5] = '{8'h00, 8'hff, 8'hff, 8'h00, 8'h00};
		do_reset();
		for (int i = 0; i < 5; i++) begin
			bus_read(6'(32 + i), v);
			check8("reset value", exp[i], v);
		end
		bus_write(6'h36, 8'hff);
		bus_read(6'h36, v);
		check8("unmapped read", 8'h00, v);
	endtask
	task automatic test_pulse_output();
		int n;
		logic [7:0] v;
		do_reset();
		bus_write(6'h01, 8'h03);
		bus_write(6'h02, 8'h01);
		bus_write(6'h04, 8'h06);
		bus_write(6'h03, 8'h09);
		time_level(1'b0, n);
		time_level(1'b1, n);
		check8("pin high cycles", 8'h10, n[7:0]);
		time_level(1'b0, n);
		check8("pin low cycles", 8'h10, n[7:0]);
		bus_read(6'h04, v);
		check8("match flags", 8'hc6, v);
	endtask
	task automatic test_overflow();
		logic [7:0] v;
		do_reset();
		bus_write(6'h08, 8'hfd);
		bus_write(6'h0b, 8'h01);
		repeat (48) @(posedge clk_in);
		bus_read(6'h0c, v);
		check8("overflow flags", 8'he0, v);
	endtask
	task automatic test_ext_reset();
		logic [7:0] v;
		do_reset();
		bus_write(6'h00, 8'h80);
		bus_write(6'h03, 8'h19);
		u_pins.pulse_pin(0);
		repeat (3) @(posedge clk_in);
		bus_read(6'h00, v);
		check1("count cleared", 1'b1, v <= 8'h03);
	endtask
	task automatic test_ext_clock();
		logic [7:0] v;
		logic [7:0] modes [3] = '{8'h05, 8'h06, 8'h07};
		logic [7:0] exp [3] = '{8'h05, 8'h05, 8'h0a};
		for (int i = 0; i < 3; i++) begin
			do_reset();
			bus_write(6'h13, modes[i]);
			u_pins.pulse_clock(2, 5);
			repeat (6) @(posedge clk_in);
			bus_read(6'h10, v);
			check8("external count", exp[i], v);
		end
	endtask
	task automatic test_cascade();
		logic [7:0] v;
		logic [5:0] b, c;
		for (int i = 0; i < 3; i++) begin
			b = 6'(16 * i);
			c = 6'(47 + i);
			do_reset();
			if (i > 0)
				bus_write(c, 8'h10);
			bus_write(b + 6'h03, 8'h04);
			bus_write(b + 6'h08, 8'hff);
			bus_write(b + 6'h0b, 8'h01);
			repeat (24) @(posedge clk_in);
			bus_read(b, v);
			check8("upper byte carry", 8'h01, v);
			do_reset();
			if (i > 0)
				bus_write(c, 8'h20);
			bus_write(b + 6'h01, 8'h01);
			bus_write(b + 6'h0b, 8'h04);
			bus_write(b + 6'h03, 8'h09);
			repeat (160) @(posedge clk_in);
			bus_read(b + 6'h08, v);
			check1("match event count", 1'b1, v >= 8'h08 && v <= 8'h0b);
		end
	endtask
	task automatic test_capture();
		logic [7:0] v;
		logic [5:0] b, c, r;
		for (int i = 0; i < 2; i++) begin
			b = 6'(24 + 16 * i);
			c = 6'(48 + i);
			r = 6'(50 + 2 * i);
			do_reset();
			bus_write(b, 8'h40);
			bus_write(b + 6'h03, 8'h01);
			bus_write(c, 8'h08);
			u_pins.pulse_pin(3 + i);
			repeat (6) @(posedge clk_in);
			bus_read(r, v);
			check1("rise capture", 1'b1, v >= 8'h40 && v <= 8'h44);
			bus_read(r + 6'h01, v);
			check1("fall capture", 1'b1, v >= 8'h40 && v <= 8'h44);
			bus_read(c, v);
			check8("capture arm", 8'h00, v);
		end
	endtask
	// Count 00f0 reaches the full match 0102 at tick 19; the next low-byte match A is tick 22.
	task automatic test_sixteen();
		logic [7:0] v;
		do_reset();
		bus_write(6'h01, 8'h01);
		bus_write(6'h09, 8'h02);
		bus_write(6'h0a, 8'h01);
		bus_write(6'h04, 8'h03);
		bus_write(6'h0c, 8'h03);
		bus_write(6'h08, 8'hf0);
		bus_write(6'h03, 8'h0c);
		bus_write(6'h0b, 8'h11);
		repeat (156) @(posedge clk_in);
		check1("pin zero", 1'b1, outs[0]);
		check1("pin one", 1'b1, outs[1]);
		bus_read(6'h04, v);
		check8("full match flags", 8'h43, v);
		bus_read(6'h00, v);
		check8("upper after clear", 8'h00, v);
		bus_read(6'h0c, v);
		check8("low byte flags", 8'he3, v);
	endtask
	// The reset pin clears the upper byte before the lower byte's own clear at count 81.
	task automatic test_split_clear();
		logic [7:0] v;
		logic [5:0] b;
		for (int i = 1; i < 3; i++) begin
			b = 6'(16 * i);
			do_reset();
			bus_write(6'(47 + i), 8'h10);
			bus_write(b, 8'h05);
			bus_write(b + 6'h09, 8'h81);
			bus_write(b + 6'h0c, 8'h03);
			bus_write(b + 6'h08, 8'h80);
			bus_write(b + 6'h03, 8'h1c);
			bus_write(b + 6'h0b, 8'h09);
			u_pins.pulse_pin(i);
			bus_read(b + 6'h08, v);
			check1("lower kept", 1'b1, v[7]);
			bus_read(b, v);
			check8("upper cleared", 8'h00, v);
			repeat (16) @(posedge clk_in);
			bus_read(b + 6'h08, v);
			check1("lower own clear", 1'b1, v <= 8'h03);
			check1("lower pin", 1'b1, outs[2 * i + 1]);
			check1("upper pin", 1'b0, outs[2 * i]);
		end
	endtask
	initial begin
		reset_in = 1'b1;
		avs_read_in = 1'b0;
		avs_write_in = 1'b0;
		avs_address_in = 6'h00;
		avs_writedata_in = 32'h0;
		avs_byteenable_in = 4'hf;
		repeat (2) @(posedge clk_in);
		reset_in <= 1'b0;
		test_reset_values();
		test_pulse_output();
		test_overflow();
		test_ext_reset();
		test_ext_clock();
		test_cascade();
		test_capture();
		test_sixteen();
		test_split_clear();
		tally_and_finish();
	end
endmodule // cet_timer_tb
`default_nettype wire
